/* File: bench/csr_core_props.sv */
// checker for the core special-register block, ports only
// assumes binding onto csr_core_regs with one clock domain
`timescale 1ns/1ps

module csr_core_props
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // requests
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic BIT_WR_I,
  input wire logic ALU_RESULT_WE_I,
  input wire logic ALU_FLAG_WE_I,
  input wire logic ALU_CARRY_I,
  input wire logic ALU_HALF_CARRY_I,
  input wire logic ALU_RANGE_ERR_I,
  input wire logic PTR_INC_I,
  input wire logic PUSH_I,
  input wire logic [7:0] PUSH_DATA_I,
  input wire logic EXT_STACK_EN_I,
  input wire logic [2:0] WREG_IDX_I,
  // results
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic [7:0] ARITH_RESULT_O,
  input wire logic [23:0] MEM_PTR_O,
  input wire logic [10:0] STACK_ADDR_O,
  input wire logic [7:0] STATUS_O,
  input wire logic [7:0] WREG_ADDR_O,
  input wire logic RAM_WE_O,
  input wire logic [10:0] RAM_ADDR_O,
  input wire logic [7:0] RAM_WDATA_O
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  stack_reset_a: assert property ($rose(RESET_N_I) |-> STACK_ADDR_O == 11'h007)
    else $error("stack address wrong after reset");
  // write lands one above the old top, never before the bump
  push_order_a: assert property (PUSH_I && EXT_STACK_EN_I && $past(EXT_STACK_EN_I)
    && !SFR_WR_I |=> RAM_WE_O && RAM_ADDR_O == $past(STACK_ADDR_O) + 11'h001
    && RAM_WDATA_O == $past(PUSH_DATA_I))
    else $error("push write misplaced");
  ram_idle_a: assert property (!PUSH_I |=> !RAM_WE_O)
    else $error("ram write without push");
  parity_flag_a: assert property (STATUS_O[0] == ^ARITH_RESULT_O)
    else $error("parity flag wrong");
  ptr_carry_a: assert property (PTR_INC_I && !SFR_WR_I |=>
    MEM_PTR_O == $past(MEM_PTR_O) + 24'h1)
    else $error("pointer increment wrong");
  low_read_a: assert property (SFR_RD_I && !SFR_ADDR_I[7] |=> SFR_RDATA_O == 8'h00)
    else $error("low address read not zero");
  upper_hidden_a: assert property (SFR_RD_I && SFR_ADDR_I == 8'hB7 && !EXT_STACK_EN_I
    |=> SFR_RDATA_O == 8'h00)
    else $error("upper stack byte visible");
  // the stack address flop is gated by the enable of the cycle before
  ext_bits_a: assert property (!$past(EXT_STACK_EN_I) |-> STACK_ADDR_O[10:8] == 3'h0)
    else $error("stack upper bits leak");
  result_read_a: assert property (SFR_RD_I && SFR_ADDR_I == 8'hE0 && !ALU_RESULT_WE_I
    && !SFR_WR_I && !BIT_WR_I |=> SFR_RDATA_O == ARITH_RESULT_O)
    else $error("accumulator read wrong");
  alu_flags_a: assert property (ALU_FLAG_WE_I && !SFR_WR_I && !BIT_WR_I |=>
    STATUS_O[7] == $past(ALU_CARRY_I) && STATUS_O[6] == $past(ALU_HALF_CARRY_I)
    && STATUS_O[2] == $past(ALU_RANGE_ERR_I))
    else $error("flag load wrong");
  // the first edge after reset still shows the reset address, so skip it
  bank_map_a: assert property ($past(RESET_N_I) && $stable(STATUS_O[4:3]) |->
    WREG_ADDR_O == {3'h0, STATUS_O[4:3], $past(WREG_IDX_I)})
    else $error("working register address wrong");
endmodule : csr_core_props

bind csr_core_regs csr_core_props u_props (.*);

/* File: bench/csr_ram_model.sv */
// far-side model: internal RAM that takes the block's push writes
// assumes the bench peeks at mem to check where bytes landed
`timescale 1ns/1ps

module csr_ram_model
(
  // clock
  input wire logic clk_i,
  // push write port
  input wire logic we_i,
  input wire logic [10:0] addr_i,
  input wire logic [7:0] wdata_i
);
  logic [7:0] mem [0:2047];

  // store each push at the address handed over
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule : csr_ram_model

/* File: bench/tb_core_special_registers.sv */
// testbench for the core special-register block
// assumes csr_core_regs, its checker and the RAM model are compiled first
`timescale 1ns/1ps

module tb_core_special_registers;
  // names match the ports so the instance can connect by name
  logic CLK_I = 1'b0, RESET_N_I = 1'b0, SFR_WR_I = 1'b0, SFR_RD_I = 1'b0, BIT_WR_I = 1'b0;
  logic BIT_VAL_I = 1'b0, ALU_RESULT_WE_I = 1'b0, ALU_AUX_WE_I = 1'b0, ALU_FLAG_WE_I = 1'b0;
  logic ALU_CARRY_I = 1'b0, ALU_HALF_CARRY_I = 1'b0, ALU_RANGE_ERR_I = 1'b0, PTR_INC_I = 1'b0;
  logic PUSH_I = 1'b0, POP_I = 1'b0, EXT_STACK_EN_I = 1'b0, RAM_WE_O;
  logic [7:0] SFR_ADDR_I = 8'h00, SFR_WDATA_I = 8'h00, BIT_ADDR_I = 8'h00, ALU_RESULT_I = 8'h00;
  logic [7:0] ALU_AUX_I = 8'h00, PUSH_DATA_I = 8'h00, SFR_RDATA_O, ARITH_RESULT_O, MUL_AUX_O;
  logic [7:0] STATUS_O, WREG_ADDR_O, RAM_WDATA_O;
  logic [2:0] WREG_IDX_I = 3'h5;
  logic [23:0] MEM_PTR_O;
  logic [10:0] STACK_ADDR_O, RAM_ADDR_O;
  int n_fail = 0;
  int cmp_count = 0;

  csr_core_regs dut (.*);
  csr_ram_model u_ram (.clk_i(CLK_I), .we_i(RAM_WE_O), .addr_i(RAM_ADDR_O),
    .wdata_i(RAM_WDATA_O));

  // free-running 4 ns core clock
  initial
  begin
    forever #2 CLK_I = ~CLK_I;
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one-cycle write strobe, outputs settled on return
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    SFR_WR_I <= 1'b1;
    SFR_ADDR_I <= a;
    SFR_WDATA_I <= d;
    @(posedge CLK_I);
    SFR_WR_I <= 1'b0;
    #1;
  endtask : wr

  // read data stands only the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK_I);
    SFR_RD_I <= 1'b1;
    SFR_ADDR_I <= a;
    @(posedge CLK_I);
    SFR_RD_I <= 1'b0;
    #1;
    chk("read data", {16'h0, exp}, {16'h0, SFR_RDATA_O});
  endtask : rd

  task automatic push(input logic [7:0] d);
    @(posedge CLK_I);
    PUSH_I <= 1'b1;
    PUSH_DATA_I <= d;
    @(posedge CLK_I);
    PUSH_I <= 1'b0;
    #1;
  endtask : push

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    #1;
    chk("stack", 24'h007, STACK_ADDR_O);
    chk("pointer", 24'h0, MEM_PTR_O);
    rd(8'hD0, 8'h00);
    wr(8'hE0, 8'h07);
    chk("parity", 24'h1, STATUS_O[0]);
    rd(8'hE0, 8'h07);
    @(posedge CLK_I);
    ALU_RESULT_WE_I <= 1'b1;
    ALU_RESULT_I <= 8'h03;
    ALU_AUX_WE_I <= 1'b1;
    ALU_AUX_I <= 8'hC3;
    @(posedge CLK_I);
    ALU_RESULT_WE_I <= 1'b0;
    ALU_AUX_WE_I <= 1'b0;
    #1;
    chk("arith result", 24'h03, ARITH_RESULT_O);
    chk("aux", 24'hC3, MUL_AUX_O);
    wr(8'hF0, 8'h5A);
    rd(8'hF0, 8'h5A);
    // carry must ripple from the high byte into the page byte
    wr(8'h84, 8'h12);
    wr(8'h83, 8'hFF);
    wr(8'h82, 8'hFF);
    chk("pointer", 24'h12FFFF, MEM_PTR_O);
    @(posedge CLK_I);
    PTR_INC_I <= 1'b1;
    @(posedge CLK_I);
    PTR_INC_I <= 1'b0;
    #1;
    chk("pointer", 24'h130000, MEM_PTR_O);
    rd(8'h84, 8'h13);
    rd(8'h83, 8'h00);
    for (int b = 0; b < 4; b++)
    begin
      wr(8'hD0, 8'(b << 3));
      @(posedge CLK_I);
      #1;
      chk("bank address", 24'(b * 8 + 5), WREG_ADDR_O);
    end
    @(posedge CLK_I);
    BIT_WR_I <= 1'b1;
    BIT_ADDR_I <= 8'hD3;
    @(posedge CLK_I);
    BIT_WR_I <= 1'b0;
    ALU_FLAG_WE_I <= 1'b1;
    ALU_CARRY_I <= 1'b1;
    ALU_RANGE_ERR_I <= 1'b1;
    @(posedge CLK_I);
    ALU_FLAG_WE_I <= 1'b0;
    #1;
    chk("flags", 24'h94, STATUS_O);
    wr(8'hD0, 8'h01);
    chk("flags", 24'h00, STATUS_O);
    push(8'hAA);
    chk("stack", 24'h008, STACK_ADDR_O);
    @(posedge CLK_I);
    #1;
    chk("ram", 24'hAA, u_ram.mem[8]);
    // upper byte stays hidden until the enable is set
    wr(8'hB7, 8'h05);
    rd(8'hB7, 8'h00);
    @(posedge CLK_I);
    EXT_STACK_EN_I <= 1'b1;
    rd(8'hB7, 8'h00);
    wr(8'hB7, 8'h05);
    rd(8'hB7, 8'h05);
    chk("stack", 24'h508, STACK_ADDR_O);
    push(8'h5C);
    @(posedge CLK_I);
    #1;
    chk("ram", 24'h5C, u_ram.mem[11'h509]);
    // a pop steps the extended address back down by one, upper bits kept
    @(posedge CLK_I);
    POP_I <= 1'b1;
    @(posedge CLK_I);
    POP_I <= 1'b0;
    #1;
    chk("stack", 24'h508, STACK_ADDR_O);
    rd(8'h81, 8'h08);
    rd(8'h50, 8'h00);
    end_sim;
  end

  // hang guard, far beyond the roughly 80 cycles needed
  initial
  begin
    #20000;
    n_fail++;
    end_sim;
  end
endmodule : tb_core_special_registers

/* File: design/csr_cfg.svh */
// constants for the core special-register block: direct addresses,
// reset values and field positions of the flag register
// assumes inclusion by the register block
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH

// direct addresses, all in the upper half of internal data space
`define CSR_ADDR_RES 8'hE0
`define CSR_ADDR_AUX 8'hF0
`define CSR_ADDR_STK 8'h81
`define CSR_ADDR_PTR_LO 8'h82
`define CSR_ADDR_PTR_HI 8'h83
`define CSR_ADDR_PTR_PG 8'h84
`define CSR_ADDR_STK_HI 8'hB7
`define CSR_ADDR_FLAGS 8'hD0

// reset values
`define CSR_RST_RES 8'h00
`define CSR_RST_AUX 8'h00
`define CSR_RST_PTR 8'h00
`define CSR_RST_STK 8'h07
`define CSR_RST_STK_HI 8'h00
`define CSR_RST_FLAGS 8'h00

// flag register bit positions
`define CSR_FLAG_CARRY 7
`define CSR_FLAG_HALF 6
`define CSR_FLAG_USER0 5
`define CSR_FLAG_BANK_HI 4
`define CSR_FLAG_BANK_LO 3
`define CSR_FLAG_RANGE 2
`define CSR_FLAG_USER1 1
`define CSR_FLAG_PARITY 0

// stack upper byte bits used by the extended stack
`define CSR_STK_HI_USED 3

`endif

/* File: design/csr_core_regs.sv */
// core special-function registers of an 8-bit controller: accumulator,
// multiply auxiliary, three-byte memory pointer, stack pointer pair and
// the cpu status flags, with direct byte access and single-bit writes to the registers at E0H, F0H and D0H
// assumes the instruction datapath drives every request input
// synchronously to CLK_I and raises at most one stack request a cycle
`timescale 1ns/1ps
`include "csr_cfg.svh"

// Function
// RULE1 - accumulator is source and target of add, sub, mul, div and bit ops
// RULE2 - auxiliary register pairs with accumulator for mul and div, else scratch
// RULE3 - memory pointer is page, high and low bytes, each read and written alone
// RULE4 - memory pointer drives the internal code and data address
// RULE5 - pointer increment carries from high byte into page byte
// RULE6 - push and call increment stack pointer first, then write RAM there
// RULE7 - stack pointer resets to 07H so first push lands at 08H
// RULE8 - extended stack address is 11 bits: upper byte low three bits plus pointer
// RULE9 - upper stack byte reads and writes only while extended stack enabled
// RULE10 - status flags sit at D0H, reset to 00H, and are bit addressable
// RULE11 - flag layout: carry, half carry, user0, bank 4:3, range, user1, parity
// RULE12 - registers live in upper 128 bytes, reached by direct address only
// RULE13 - parity flag follows accumulator even parity every cycle
// RULE14 - bank select maps R0..R7 onto bank times eight plus index
module csr_core_regs
  import csr_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // direct byte access
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  // single-bit access
  input wire logic BIT_WR_I,
  input wire logic [7:0] BIT_ADDR_I,
  input wire logic BIT_VAL_I,
  // arithmetic unit results
  input wire logic ALU_RESULT_WE_I,
  input wire logic [7:0] ALU_RESULT_I,
  input wire logic ALU_AUX_WE_I,
  input wire logic [7:0] ALU_AUX_I,
  input wire logic ALU_FLAG_WE_I,
  input wire logic ALU_CARRY_I,
  input wire logic ALU_HALF_CARRY_I,
  input wire logic ALU_RANGE_ERR_I,
  // pointer and stack requests
  input wire logic PTR_INC_I,
  input wire logic PUSH_I,
  input wire logic POP_I,
  input wire logic [7:0] PUSH_DATA_I,
  // configuration
  input wire logic EXT_STACK_EN_I,
  // working register lookup
  input wire logic [2:0] WREG_IDX_I,
  // register contents towards the datapath
  output logic [7:0] ARITH_RESULT_O,
  output logic [7:0] MUL_AUX_O,
  output logic [23:0] MEM_PTR_O,
  output logic [10:0] STACK_ADDR_O,
  output logic [7:0] STATUS_O,
  output logic [7:0] WREG_ADDR_O,
  // internal RAM write for pushes
  output logic RAM_WE_O,
  output logic [10:0] RAM_ADDR_O,
  output logic [7:0] RAM_WDATA_O
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  csr_byte_t arith_result_reg;
  csr_byte_t mul_aux_reg;
  csr_byte_t pointer_page_byte;
  csr_byte_t pointer_high_byte;
  csr_byte_t pointer_low_byte;
  csr_byte_t stack_top_pointer;
  csr_byte_t stack_pointer_upper;
  csr_byte_t cpu_status_flags;
  csr_byte_t rdata;
  csr_byte_t wreg_addr;
  logic ram_we;
  csr_stack_addr_t ram_addr;
  csr_byte_t ram_wdata;
  csr_stack_addr_t stack_addr;

  csr_byte_t next_arith_result_reg;
  csr_byte_t next_mul_aux_reg;
  csr_byte_t next_pointer_page_byte;
  csr_byte_t next_pointer_high_byte;
  csr_byte_t next_pointer_low_byte;
  csr_byte_t next_stack_top_pointer;
  csr_byte_t next_stack_pointer_upper;
  csr_byte_t next_cpu_status_flags;
  csr_byte_t next_rdata;
  csr_byte_t next_wreg_addr;
  logic next_ram_we;
  csr_stack_addr_t next_ram_addr;
  csr_byte_t next_ram_wdata;
  csr_stack_addr_t next_stack_addr;

  // helper nets
  csr_stk_op_e stk_op;
  csr_stack_addr_t stk_now;
  csr_stack_addr_t stk_step;
  csr_ptr_t ptr_step;
  logic dir_wr;
  logic bit_wr;
  logic dir_rd;
  logic result_parity;

  // ------------------------------------------------------------
  // access qualifiers
  // ------------------------------------------------------------
  // addresses below 80H are plain RAM, never these registers
  assign dir_wr = SFR_WR_I & SFR_ADDR_I[7]; // RULE12
  assign dir_rd = SFR_RD_I & SFR_ADDR_I[7]; // RULE12
  assign bit_wr = BIT_WR_I & BIT_ADDR_I[7]; // RULE10

  // only registers on an eight-byte boundary take bit writes
  function automatic csr_byte_t sfr_upd(input csr_byte_t cur, input csr_byte_t where);
    csr_byte_t res;
    res = cur;
    if (dir_wr && SFR_ADDR_I == where)
    begin
      res = SFR_WDATA_I;
    end
    if (bit_wr && where[2:0] == 3'h0 && {BIT_ADDR_I[7:3], 3'h0} == where)
    begin
      res[BIT_ADDR_I[2:0]] = BIT_VAL_I; // RULE10
    end
    return res;
  endfunction : sfr_upd

  // ------------------------------------------------------------
  // parity of the accumulator value about to be stored
  // ------------------------------------------------------------
  csr_parity u_parity
  (
    .data_i(next_arith_result_reg),
    .parity_o(result_parity)
  );

  // ------------------------------------------------------------
  // stack request decode
  // ------------------------------------------------------------
  // push wins if the datapath ever raises both
  always_comb
  begin
    if (PUSH_I)
    begin
      stk_op = CSR_STK_PUSH;
    end
    else if (POP_I)
    begin
      stk_op = CSR_STK_POP;
    end
    else
    begin
      stk_op = CSR_STK_IDLE;
    end
  end

  // current stack address, upper bits only while extended
  assign stk_now = EXT_STACK_EN_I ?
    {stack_pointer_upper[`CSR_STK_HI_USED-1:0], stack_top_pointer} :
    {3'h0, stack_top_pointer}; // RULE8

  // ------------------------------------------------------------
  // next values of all registers except the read data
  // ------------------------------------------------------------
  // a direct write in the same cycle as a datapath update wins,
  // since software expects its own store to stick
  always_comb
  begin
    // accumulator: arithmetic result or direct store
    next_arith_result_reg = arith_result_reg;
    if (ALU_RESULT_WE_I)
    begin
      next_arith_result_reg = ALU_RESULT_I; // RULE1
    end
    next_arith_result_reg = sfr_upd(next_arith_result_reg, `CSR_ADDR_RES);

    // auxiliary: second mul/div result, otherwise scratch
    next_mul_aux_reg = mul_aux_reg;
    if (ALU_AUX_WE_I)
    begin
      next_mul_aux_reg = ALU_AUX_I; // RULE2
    end
    next_mul_aux_reg = sfr_upd(next_mul_aux_reg, `CSR_ADDR_AUX); // RULE2

    // pointer: 24-bit increment so the high byte carries into page
    ptr_step = {pointer_page_byte, pointer_high_byte, pointer_low_byte};
    if (PTR_INC_I)
    begin
      ptr_step = ptr_step + 24'h000001; // RULE5
    end
    next_pointer_page_byte = sfr_upd(ptr_step[23:16], `CSR_ADDR_PTR_PG); // RULE3
    next_pointer_high_byte = sfr_upd(ptr_step[15:8], `CSR_ADDR_PTR_HI); // RULE3
    next_pointer_low_byte = sfr_upd(ptr_step[7:0], `CSR_ADDR_PTR_LO); // RULE3

    // stack: step before the write, so the push lands one above
    stk_step = stk_now;
    next_ram_we = 1'b0;
    next_ram_addr = ram_addr;
    next_ram_wdata = ram_wdata;
    unique case (stk_op)
      CSR_STK_PUSH:
      begin
        stk_step = stk_now + 11'h001; // RULE6
        next_ram_we = 1'b1; // RULE6
        next_ram_wdata = PUSH_DATA_I;
      end
      CSR_STK_POP:
      begin
        stk_step = stk_now - 11'h001;
      end
      CSR_STK_IDLE:
      begin
        stk_step = stk_now;
      end
    endcase
    // without the extension the pointer wraps inside 256 bytes
    if (!EXT_STACK_EN_I)
    begin
      stk_step[10:8] = 3'h0;
    end
    if (next_ram_we)
    begin
      next_ram_addr = stk_step; // RULE6
    end
    next_stack_top_pointer = sfr_upd(stk_step[7:0], `CSR_ADDR_STK);
    next_stack_pointer_upper = stack_pointer_upper;
    if (EXT_STACK_EN_I)
    begin
      next_stack_pointer_upper[`CSR_STK_HI_USED-1:0] = stk_step[10:8]; // RULE8
      next_stack_pointer_upper = sfr_upd(next_stack_pointer_upper, `CSR_ADDR_STK_HI); // RULE9
    end
    // registered copy keeps the output a flop; it follows an enable change one edge late
    next_stack_addr = {next_stack_pointer_upper[`CSR_STK_HI_USED-1:0] & {3{EXT_STACK_EN_I}},
      next_stack_top_pointer}; // RULE8

    // status flags: arithmetic flags, then direct or bit store
    next_cpu_status_flags = cpu_status_flags;
    if (ALU_FLAG_WE_I)
    begin
      next_cpu_status_flags[`CSR_FLAG_CARRY] = ALU_CARRY_I; // RULE11
      next_cpu_status_flags[`CSR_FLAG_HALF] = ALU_HALF_CARRY_I; // RULE11
      next_cpu_status_flags[`CSR_FLAG_RANGE] = ALU_RANGE_ERR_I; // RULE11
    end
    next_cpu_status_flags = sfr_upd(next_cpu_status_flags, `CSR_ADDR_FLAGS); // RULE10
    // parity is forced last, so any store to it is overwritten
    next_cpu_status_flags[`CSR_FLAG_PARITY] = result_parity; // RULE13

    // working register address from the bank select pair
    next_wreg_addr = {3'h0, next_cpu_status_flags[`CSR_FLAG_BANK_HI],
      next_cpu_status_flags[`CSR_FLAG_BANK_LO], WREG_IDX_I}; // RULE14
  end

  // ------------------------------------------------------------
  // read mux, answers one cycle after the request
  // ------------------------------------------------------------
  // unmapped and low addresses read as zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (dir_rd)
    begin
      unique case (SFR_ADDR_I)
        `CSR_ADDR_RES: next_rdata = arith_result_reg; // RULE1
        `CSR_ADDR_AUX: next_rdata = mul_aux_reg;
        `CSR_ADDR_PTR_PG: next_rdata = pointer_page_byte; // RULE3
        `CSR_ADDR_PTR_HI: next_rdata = pointer_high_byte; // RULE3
        `CSR_ADDR_PTR_LO: next_rdata = pointer_low_byte; // RULE3
        `CSR_ADDR_STK: next_rdata = stack_top_pointer;
        `CSR_ADDR_STK_HI: next_rdata = EXT_STACK_EN_I ? stack_pointer_upper : 8'h00; // RULE9
        `CSR_ADDR_FLAGS: next_rdata = cpu_status_flags; // RULE10
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      arith_result_reg <= `CSR_RST_RES;
      mul_aux_reg <= `CSR_RST_AUX;
      pointer_page_byte <= `CSR_RST_PTR;
      pointer_high_byte <= `CSR_RST_PTR;
      pointer_low_byte <= `CSR_RST_PTR;
      stack_top_pointer <= `CSR_RST_STK; // RULE7
      stack_pointer_upper <= `CSR_RST_STK_HI;
      cpu_status_flags <= `CSR_RST_FLAGS; // RULE10
      stack_addr <= {3'h0, `CSR_RST_STK}; // RULE7
      rdata <= 8'h00;
      wreg_addr <= 8'h00;
      ram_we <= 1'b0;
      ram_addr <= 11'h000;
      ram_wdata <= 8'h00;
    end
    else
    begin
      arith_result_reg <= next_arith_result_reg;
      mul_aux_reg <= next_mul_aux_reg;
      pointer_page_byte <= next_pointer_page_byte;
      pointer_high_byte <= next_pointer_high_byte;
      pointer_low_byte <= next_pointer_low_byte;
      stack_top_pointer <= next_stack_top_pointer;
      stack_pointer_upper <= next_stack_pointer_upper;
      cpu_status_flags <= next_cpu_status_flags;
      rdata <= next_rdata;
      wreg_addr <= next_wreg_addr;
      ram_we <= next_ram_we;
      ram_addr <= next_ram_addr;
      ram_wdata <= next_ram_wdata;
      stack_addr <= next_stack_addr;
    end
  end

  // ------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ------------------------------------------------------------
  assign ARITH_RESULT_O = arith_result_reg; // RULE1
  assign MUL_AUX_O = mul_aux_reg; // RULE2
  assign MEM_PTR_O = {pointer_page_byte, pointer_high_byte, pointer_low_byte}; // RULE4
  // stack address comes from its own flop, gated as it was stored
  assign STACK_ADDR_O = stack_addr; // RULE8
  assign STATUS_O = cpu_status_flags;
  assign WREG_ADDR_O = wreg_addr;
  assign SFR_RDATA_O = rdata;
  assign RAM_WE_O = ram_we;
  assign RAM_ADDR_O = ram_addr;
  assign RAM_WDATA_O = ram_wdata;

endmodule : csr_core_regs

/* File: design/csr_parity.sv */
// even-parity generator for one byte
// assumes a purely combinational use by the register block
`timescale 1ns/1ps

module csr_parity
(
  // data in
  input wire logic [7:0] data_i,
  // one when data holds an odd count of ones
  output logic parity_o
);

  logic [8:0] chain;

  // ------------------------------------------------------------
  // xor chain across the byte
  // ------------------------------------------------------------
  assign chain[0] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_bit
      assign chain[gi + 1] = chain[gi] ^ data_i[gi];
    end
  endgenerate

  assign parity_o = chain[8];

endmodule : csr_parity

/* File: design/csr_pkg.sv */
// types shared by the core special-register block
// assumes csr_cfg.svh sits in the include path
package csr_pkg;

  typedef logic [7:0] csr_byte_t;
  typedef logic [10:0] csr_stack_addr_t;
  typedef logic [23:0] csr_ptr_t;

  // stack operation requested this cycle, one-hot
  typedef enum logic [2:0]
  {
    CSR_STK_IDLE = 3'h1,
    CSR_STK_PUSH = 3'h2,
    CSR_STK_POP = 3'h4
  } csr_stk_op_e;

endpackage : csr_pkg
